// ==== hdl/stls_mode_sel.sv ====
// Per-quad mode decode and field set selection, purely combinational.
// Assumes the PHY state inputs are synchronous to the core clock.
`timescale 1ns/1ps
`default_nettype none
module stls_mode_sel
    import stls_pkg::*;
(
    // PHY state of the port
    input wire logic low_swing_i,
    input wire logic gen2_i,
    input wire logic deemph_6db_i,
    // Level registers of the quad
    input wire logic [31:0] ctl_a_i,
    input wire logic [31:0] ctl_b_i,
    // Selected field set
    output stls_mode_type mode_o,
    output logic [DRIVE_W-1:0] drive_o,
    output logic [COARSE_W-1:0] coarse_o,
    output logic [FINE_W-1:0] fine_o
);

    // Mode from swing, rate and de-emphasis; low swing ignores the 6 dB bit
    always_comb begin
        if (low_swing_i) begin
            mode_o = gen2_i ? MODE_LOW_G2 : MODE_LOW_G1;
        end else if (!gen2_i) begin
            mode_o = MODE_FULL_G1; // -6 dB exists only at Gen 2
        end else begin
            mode_o = deemph_6db_i ? MODE_FULL_G2_6DB : MODE_FULL_G2_3DB;
        end
    end

    // Field set per mode, low swing forces de-emphasis to zero
    always_comb begin
        drive_o = '0;
        coarse_o = '0;
        fine_o = '0;
        case (mode_o)
            MODE_FULL_G1: begin
                fine_o = ctl_a_i[POS_FINE_FULL_G1 +: FINE_W];
                drive_o = ctl_b_i[POS_DRIVE_FULL_G1 +: DRIVE_W];
                coarse_o = ctl_b_i[POS_COARSE_FULL_G1 +: COARSE_W];
            end
            MODE_FULL_G2_3DB: begin
                fine_o = ctl_a_i[POS_FINE_FULL_G2_3DB +: FINE_W];
                drive_o = ctl_b_i[POS_DRIVE_FULL_G2_3DB +: DRIVE_W];
                coarse_o = ctl_b_i[POS_COARSE_FULL_G2_3DB +: COARSE_W];
            end
            MODE_FULL_G2_6DB: begin
                fine_o = ctl_a_i[POS_FINE_FULL_G2_6DB +: FINE_W];
                drive_o = ctl_b_i[POS_DRIVE_FULL_G2_6DB +: DRIVE_W];
                coarse_o = ctl_b_i[POS_COARSE_FULL_G2_6DB +: COARSE_W];
            end
            MODE_LOW_G1: begin
                drive_o = {1'b0, ctl_b_i[POS_DRIVE_LOW_G1 +: LOW_DRIVE_W]};
            end
            MODE_LOW_G2: begin
                drive_o = {1'b0, ctl_b_i[POS_DRIVE_LOW_G2 +: LOW_DRIVE_W]};
            end
            default: begin
                drive_o = '0;
            end
        endcase
    end

endmodule
`default_nettype wire

// ==== hdl/stls_pkg.sv ====
// Constants, types and helpers shared by the transmitter level select block.
// Assumes a 32-bit register bus and quads of four lanes each.
package stls_pkg;

    // -------------------------------------------------------------------
    // Register map, one 16-byte window per quad
    // -------------------------------------------------------------------
    localparam int unsigned QUAD_STRIDE = 16;
    localparam logic [3:0] OFS_LEVEL_CTL_A = 4'h0;
    localparam logic [3:0] OFS_LEVEL_CTL_B = 4'h4;
    localparam logic [3:0] OFS_LANE_SEL = 4'h8;
    localparam logic [3:0] OFS_MODE_STAT = 4'hC;

    // -------------------------------------------------------------------
    // Field widths and positions
    // -------------------------------------------------------------------
    localparam int unsigned FINE_W = 2;
    localparam int unsigned COARSE_W = 3;
    localparam int unsigned DRIVE_W = 5;
    localparam int unsigned LOW_DRIVE_W = 4;
    localparam int unsigned MARGIN_W = 3;
    // First register: fine de-emphasis per full-swing mode
    localparam int unsigned POS_FINE_FULL_G1 = 0;
    localparam int unsigned POS_FINE_FULL_G2_3DB = 8;
    localparam int unsigned POS_FINE_FULL_G2_6DB = 16;
    // Second register: drive level and coarse de-emphasis
    localparam int unsigned POS_DRIVE_FULL_G1 = 0;
    localparam int unsigned POS_COARSE_FULL_G1 = 5;
    localparam int unsigned POS_DRIVE_FULL_G2_3DB = 8;
    localparam int unsigned POS_COARSE_FULL_G2_3DB = 13;
    localparam int unsigned POS_DRIVE_FULL_G2_6DB = 16;
    localparam int unsigned POS_COARSE_FULL_G2_6DB = 21;
    localparam int unsigned POS_DRIVE_LOW_G1 = 24;
    localparam int unsigned POS_DRIVE_LOW_G2 = 28;
    // Lane select register
    localparam int unsigned POS_LANE_IDX = 0;
    localparam int unsigned POS_LANE_ALL = 4;

    // -------------------------------------------------------------------
    // Reset values and write masks
    // -------------------------------------------------------------------
    localparam logic [31:0] RST_LEVEL_CTL_A = 32'h0003_0302;
    localparam logic [31:0] RST_LEVEL_CTL_B = 32'h8875_7A70;
    localparam logic [31:0] RST_LANE_SEL = 32'h0000_0010;
    localparam logic [31:0] WMASK_LEVEL_CTL_A = 32'h0003_0303;
    localparam logic [31:0] WMASK_LANE_SEL = 32'h0000_0013;
    localparam logic [2:0] MARGIN_NORMAL = 3'h0;

    // PHY operating modes
    typedef enum logic [2:0] {
        MODE_FULL_G1,
        MODE_FULL_G2_3DB,
        MODE_FULL_G2_6DB,
        MODE_LOW_G1,
        MODE_LOW_G2
    } stls_mode_type;

    // True when the lane select value addresses this lane
    function automatic logic stls_lane_hit(input logic [31:0] sel, input int unsigned lane);
        stls_lane_hit = sel[POS_LANE_ALL] || (sel[POS_LANE_IDX +: 2] == lane[1:0]);
    endfunction

endpackage

// ==== hdl/stls_top.sv ====
// Transmitter level select register bank with per-lane SerDes outputs.
// Assumes an Avalon-MM master on the core clock and PHY state inputs
// synchronous to the same clock.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Each quad owns a pair of level registers setting drive level and de-emphasis of its lanes.
// - Five PHY modes are told apart: full swing G1 -3.5 dB, G2 -3.5 dB, G2 -6 dB, low swing G1 and G2.
// - After reset the level registers hold working defaults that software may overwrite.
// - A change of PHY mode makes the selected lanes take the field set of the new mode without help; the others keep their last settings.
// - Full-swing modes use their own fine field in the first register and drive and coarse in the second.
// - Three lane parameters exist: fine de-emphasis, coarse de-emphasis and drive level.
// - A write to a level field of the current mode reaches the selected lanes one clock after it lands.
// - No link retrain is needed for new level settings to apply.
// - The lane select register picks one lane or all lanes of the quad to receive the settings.
// - Only a normal transmit margin lets the registers rule; any other margin drives all lanes of its quad directly.
// - Low swing forces de-emphasis to zero and ignores the de-emphasis select bit.
module stls_top
    import stls_pkg::*;
#(
    parameter int unsigned QUADS = 2,
    parameter int unsigned LANES = 4,
    parameter int unsigned ADDR_W = 8
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Avalon-MM slave
    input wire logic [ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // PHY state per quad
    input wire logic [QUADS-1:0] low_swing_i,
    input wire logic [QUADS-1:0] gen2_i,
    input wire logic [QUADS-1:0] deemph_6db_i,
    input wire logic [QUADS-1:0][MARGIN_W-1:0] transmit_margin_field_i,
    // SerDes lane controls
    output logic [QUADS*LANES-1:0][DRIVE_W-1:0] drive_level_o,
    output logic [QUADS*LANES-1:0][COARSE_W-1:0] coarse_deemph_o,
    output logic [QUADS*LANES-1:0][FINE_W-1:0] fine_deemph_o,
    output logic [QUADS*LANES-1:0] margin_direct_o,
    output logic [QUADS*LANES-1:0][MARGIN_W-1:0] margin_level_o
);

    // -------------------------------------------------------------------
    // Elaboration checks
    // -------------------------------------------------------------------
    if (LANES != 4) begin : g_bad_lanes
        $error("stls_top: lane select field serves exactly four lanes");
    end
    if (QUADS < 1 || QUADS * QUAD_STRIDE > (1 << ADDR_W)) begin : g_bad_quads
        $error("stls_top: address width too small for the quads");
    end

    // -------------------------------------------------------------------
    // Register state
    // -------------------------------------------------------------------
    logic [QUADS-1:0][31:0] ctl_a_q;
    logic [QUADS-1:0][31:0] ctl_b_q;
    logic [QUADS-1:0][31:0] lane_sel_q;
    logic ack_q;
    stls_mode_type mode_w [QUADS];
    logic [QUADS-1:0][DRIVE_W-1:0] sel_drive_w;
    logic [QUADS-1:0][COARSE_W-1:0] sel_coarse_w;
    logic [QUADS-1:0][FINE_W-1:0] sel_fine_w;

    logic req_w;
    logic commit_w;
    int unsigned quad_w;
    logic [3:0] ofs_w;
    logic hit_w;
    assign req_w = avs_read_i || avs_write_i;
    assign commit_w = req_w && ack_q;
    assign quad_w = int'(avs_address_i) / QUAD_STRIDE;
    assign ofs_w = avs_address_i[3:0];
    assign hit_w = (quad_w < QUADS) && (ofs_w[1:0] == 2'b00);

    // -------------------------------------------------------------------
    // Bus handshake: one wait cycle, then the request completes
    // -------------------------------------------------------------------
    // Waitrequest is its own flop, so the pin never glitches on address decode
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            ack_q <= 1'b0;
            avs_waitrequest_o <= 1'b1;
        end else begin
            ack_q <= req_w && !ack_q;
            avs_waitrequest_o <= !(req_w && !ack_q);
        end
    end

    // Read data is captured in the wait cycle and stands while waitrequest is low
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && !ack_q) begin
            avs_readdata_o <= 32'h0000_0000; // Unmapped reads return zero
            if (hit_w) begin
                case (ofs_w)
                    OFS_LEVEL_CTL_A: avs_readdata_o <= ctl_a_q[quad_w];
                    OFS_LEVEL_CTL_B: avs_readdata_o <= ctl_b_q[quad_w];
                    OFS_LANE_SEL: avs_readdata_o <= lane_sel_q[quad_w];
                    OFS_MODE_STAT: avs_readdata_o <= {29'h0000_0000, mode_w[quad_w]};
                    default: avs_readdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // -------------------------------------------------------------------
    // Per-quad registers and lanes
    // -------------------------------------------------------------------
    for (genvar q = 0; q < QUADS; q++) begin : g_quad
        logic wr_w;
        assign wr_w = avs_write_i && commit_w && hit_w && (quad_w == q);

        // Level and lane select registers; writes land on the accepting edge
        always_ff @(posedge mclk_i) begin
            if (!rst_n_i) begin
                ctl_a_q[q] <= RST_LEVEL_CTL_A;
                ctl_b_q[q] <= RST_LEVEL_CTL_B;
                lane_sel_q[q] <= RST_LANE_SEL;
            end else if (wr_w) begin
                case (ofs_w)
                    OFS_LEVEL_CTL_A: ctl_a_q[q] <= avs_writedata_i & WMASK_LEVEL_CTL_A;
                    OFS_LEVEL_CTL_B: ctl_b_q[q] <= avs_writedata_i;
                    OFS_LANE_SEL: lane_sel_q[q] <= avs_writedata_i & WMASK_LANE_SEL;
                    default: ctl_b_q[q] <= ctl_b_q[q];
                endcase
            end
        end

        stls_mode_sel stls_mode_sel_inst (
            .low_swing_i(low_swing_i[q]),
            .gen2_i(gen2_i[q]),
            .deemph_6db_i(deemph_6db_i[q]),
            .ctl_a_i(ctl_a_q[q]),
            .ctl_b_i(ctl_b_q[q]),
            .mode_o(mode_w[q]),
            .drive_o(sel_drive_w[q]),
            .coarse_o(sel_coarse_w[q]),
            .fine_o(sel_fine_w[q])
        );

        for (genvar l = 0; l < LANES; l++) begin : g_lane
            localparam int unsigned IDX = q * LANES + l;
            // Selected lanes follow the live field set; others keep their last settings.
            // Margin override is port wide, so it ignores the lane select.
            always_ff @(posedge mclk_i) begin
                if (!rst_n_i) begin
                    drive_level_o[IDX] <= RST_LEVEL_CTL_B[POS_DRIVE_FULL_G1 +: DRIVE_W];
                    coarse_deemph_o[IDX] <= RST_LEVEL_CTL_B[POS_COARSE_FULL_G1 +: COARSE_W];
                    fine_deemph_o[IDX] <= RST_LEVEL_CTL_A[POS_FINE_FULL_G1 +: FINE_W];
                    margin_direct_o[IDX] <= 1'b0;
                    margin_level_o[IDX] <= MARGIN_NORMAL;
                end else begin
                    margin_direct_o[IDX] <= (transmit_margin_field_i[q] != MARGIN_NORMAL);
                    margin_level_o[IDX] <= transmit_margin_field_i[q];
                    if (stls_lane_hit(lane_sel_q[q], l)) begin
                        drive_level_o[IDX] <= sel_drive_w[q];
                        coarse_deemph_o[IDX] <= sel_coarse_w[q];
                        fine_deemph_o[IDX] <= sel_fine_w[q];
                    end
                end
            end
        end
    end

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    a_wait_once: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        req_w && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("request not answered after one wait cycle");
    a_wait_rearm: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low for more than one cycle");
    a_reset_defaults: assert property (@(posedge mclk_i)
        !rst_n_i |=> ctl_a_q[0] == RST_LEVEL_CTL_A && ctl_b_q[0] == RST_LEVEL_CTL_B)
        else $error("level registers not at defaults after reset");
    a_write_lands: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        avs_write_i && !avs_waitrequest_o && avs_address_i == ADDR_W'(OFS_LEVEL_CTL_B)
        |=> ctl_b_q[0] == $past(avs_writedata_i))
        else $error("write to level register lost");
    a_write_to_lane: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        avs_write_i && !avs_waitrequest_o && avs_address_i == ADDR_W'(OFS_LEVEL_CTL_B)
        && lane_sel_q[0][POS_LANE_ALL] && !low_swing_i[0] && !gen2_i[0] ##1 !low_swing_i[0] && !gen2_i[0]
        |=> drive_level_o[0] == $past(avs_writedata_i[POS_DRIVE_FULL_G1 +: DRIVE_W], 2))
        else $error("level write did not reach the lane");
    a_mode_follow: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        stls_lane_hit(lane_sel_q[0], 0) |=> drive_level_o[0] == $past(sel_drive_w[0])
        && fine_deemph_o[0] == $past(sel_fine_w[0]))
        else $error("lane did not follow the mode field set");
    a_low_no_deemph: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        low_swing_i[0] && lane_sel_q[0][POS_LANE_ALL]
        |=> coarse_deemph_o[LANES-1] == '0 && fine_deemph_o[LANES-1] == '0)
        else $error("de-emphasis not zero in low swing");
    a_mode_6db: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        gen2_i[0] && deemph_6db_i[0] |-> mode_w[0] == (low_swing_i[0] ? MODE_LOW_G2 : MODE_FULL_G2_6DB))
        else $error("wrong mode decode at Gen 2");
    a_margin_all: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        transmit_margin_field_i[0] != MARGIN_NORMAL |=> margin_direct_o[0] && margin_direct_o[LANES-1]
        && margin_level_o[0] == $past(transmit_margin_field_i[0]))
        else $error("margin override not applied to all lanes");
    a_lane_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !stls_lane_hit(lane_sel_q[0], 1) |=> $stable(drive_level_o[1]))
        else $error("unselected lane changed");
    a_wait_idle: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !req_w |=> avs_waitrequest_o)
        else $error("waitrequest low without a request");
    a_fine_full_g1: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        !low_swing_i[0] && !gen2_i[0] && lane_sel_q[0][POS_LANE_ALL]
        |=> fine_deemph_o[2] == $past(ctl_a_q[0][POS_FINE_FULL_G1 +: FINE_W])
        && coarse_deemph_o[2] == $past(ctl_b_q[0][POS_COARSE_FULL_G1 +: COARSE_W]))
        else $error("full swing Gen 1 fields not on the lane");

endmodule
`default_nettype wire

// ==== test/stls_lane_model.sv ====
// Behavioural model of the analog transmitter lanes fed by the level select block.
// Assumes lane controls are synchronous to the core clock; it latches them each edge.
`timescale 1ns/1ps
`default_nettype none
module stls_lane_model
    import stls_pkg::*;
#(
    parameter int unsigned NL = 8
) (
    // Clock
    input wire logic mclk_i,
    // Lane controls from the block
    input wire logic [NL-1:0][DRIVE_W-1:0] drive_level_i,
    input wire logic [NL-1:0][COARSE_W-1:0] coarse_deemph_i,
    input wire logic [NL-1:0][FINE_W-1:0] fine_deemph_i,
    input wire logic [NL-1:0] margin_direct_i,
    input wire logic [NL-1:0][MARGIN_W-1:0] margin_level_i,
    // Settings the driver really applies
    output logic [NL-1:0][DRIVE_W-1:0] eff_level_o,
    output logic [NL-1:0][COARSE_W+FINE_W-1:0] eff_deemph_o
);
    // Driver latches its three parameters; margin overrides the level directly
    always_ff @(posedge mclk_i) begin
        for (int i = 0; i < NL; i++) begin
            eff_level_o[i] <= margin_direct_i[i] ? DRIVE_W'(margin_level_i[i]) : drive_level_i[i];
            eff_deemph_o[i] <= margin_direct_i[i] ? '0 : {coarse_deemph_i[i], fine_deemph_i[i]};
        end
    end
endmodule
`default_nettype wire

// ==== test/test_serdes_tx_level_select.sv ====
// Self-checking bench for the transmitter level select block, two quads.
// Assumes an Avalon-MM slave with one wait cycle and registered lane outputs.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin $display("BAD %s exp %h got %h", nm, ex, gt); err_total++; end end
module test_serdes_tx_level_select;
    import stls_pkg::*;
    // -------------------------------------------------------------------
    // Signals
    // -------------------------------------------------------------------
    logic mclk_i, rst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o;
    logic [7:0] avs_address_i;
    logic [31:0] avs_writedata_i, avs_readdata_o;
    logic [1:0] low_swing_i, gen2_i, deemph_6db_i;
    logic [1:0][MARGIN_W-1:0] transmit_margin_field_i;
    logic [7:0][DRIVE_W-1:0] drive_level_o, eff_level;
    logic [7:0][COARSE_W-1:0] coarse_deemph_o;
    logic [7:0][FINE_W-1:0] fine_deemph_o;
    logic [7:0][COARSE_W+FINE_W-1:0] eff_deemph;
    logic [7:0] margin_direct_o;
    logic [7:0][MARGIN_W-1:0] margin_level_o;
    int err_total = 0;
    int n_checks = 0;
    logic [31:0] a0, b0, rd;
    // Swing, rate, 6 dB select for each mode in enum order
    localparam logic [2:0] MTAB [5] = '{3'h0, 3'h2, 3'h3, 3'h5, 3'h7};

    stls_top #(.QUADS(2), .LANES(4), .ADDR_W(8)) stls_top_inst (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .low_swing_i(low_swing_i), .gen2_i(gen2_i),
        .deemph_6db_i(deemph_6db_i), .transmit_margin_field_i(transmit_margin_field_i),
        .drive_level_o(drive_level_o), .coarse_deemph_o(coarse_deemph_o), .fine_deemph_o(fine_deemph_o),
        .margin_direct_o(margin_direct_o), .margin_level_o(margin_level_o));
    stls_lane_model #(.NL(8)) stls_lane_model_inst (
        .mclk_i(mclk_i), .drive_level_i(drive_level_o), .coarse_deemph_i(coarse_deemph_o),
        .fine_deemph_i(fine_deemph_o), .margin_direct_i(margin_direct_o), .margin_level_i(margin_level_o),
        .eff_level_o(eff_level), .eff_deemph_o(eff_deemph));

    // -------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------
    // Field set a lane should carry, built from field positions of each mode
    function automatic logic [9:0] exp_set(input int m, input logic [31:0] a, input logic [31:0] b);
        case (m)
            0: exp_set = {b[4:0], b[7:5], a[1:0]};
            1: exp_set = {b[12:8], b[15:13], a[9:8]};
            2: exp_set = {b[20:16], b[23:21], a[17:16]};
            3: exp_set = {1'b0, b[27:24], 5'h00};
            default: exp_set = {1'b0, b[31:28], 5'h00};
        endcase
    endfunction

    task automatic finish_test();
        if (err_total == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // One Avalon transfer; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rdat);
        logic done;
        done = 1'b0;
        @(posedge mclk_i);
        avs_read_i <= !wr;
        avs_write_i <= wr;
        avs_address_i <= adr;
        avs_writedata_i <= wd;
        for (int k = 0; k < 20 && !done; k++) begin
            @(posedge mclk_i);
            done = (avs_waitrequest_o === 1'b0);
        end
        rdat = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        if (!done) begin
            err_total++;
            finish_test();
        end
    endtask

    // Let a register or PHY change reach lanes and the lane model
    task automatic settle();
        repeat (3) @(posedge mclk_i);
        #1;
    endtask

    task automatic set_mode(input int q, input int m);
        @(posedge mclk_i);
        low_swing_i[q] <= MTAB[m][2];
        gen2_i[q] <= MTAB[m][1];
        deemph_6db_i[q] <= MTAB[m][0];
        settle();
    endtask

    // Lanes of quad q: selected ones show en, the others eo
    task automatic chk_quad(input int q, input logic [3:0] sel, input logic [9:0] en, input logic [9:0] eo);
        for (int l = 0; l < 4; l++)
            `CHK("lane", sel[l] ? en : eo, {drive_level_o[q*4+l], coarse_deemph_o[q*4+l], fine_deemph_o[q*4+l]})
    endtask

    // -------------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------------
    task automatic t_reset();
        for (int q = 0; q < 2; q++) begin
            bus(1'b0, 8'(q*16) | OFS_LEVEL_CTL_A, 32'h0000_0000, rd);
            `CHK("ctl_a", RST_LEVEL_CTL_A, rd)
            bus(1'b0, 8'(q*16) | OFS_LEVEL_CTL_B, 32'h0000_0000, rd);
            `CHK("ctl_b", RST_LEVEL_CTL_B, rd)
            bus(1'b0, 8'(q*16) | OFS_LANE_SEL, 32'h0000_0000, rd);
            `CHK("lane_sel", RST_LANE_SEL, rd)
            chk_quad(q, 4'hF, exp_set(0, RST_LEVEL_CTL_A, RST_LEVEL_CTL_B), 10'h000);
        end
    endtask

    task automatic t_modes();
        for (int m = 0; m < 5; m++) begin
            set_mode(0, m);
            bus(1'b0, OFS_MODE_STAT, 32'h0000_0000, rd);
            `CHK("mode", 3'(m), rd[2:0])
            chk_quad(0, 4'hF, exp_set(m, a0, b0), 10'h000);
            chk_quad(1, 4'hF, exp_set(0, RST_LEVEL_CTL_A, RST_LEVEL_CTL_B), 10'h000);
        end
        set_mode(0, 1);
    endtask

    // Live-link level writes; a real driver of this would be careful
    task automatic t_write();
        bus(1'b1, OFS_LEVEL_CTL_A, 32'hFFFF_FEFD, rd);
        a0 = 32'hFFFF_FEFD & WMASK_LEVEL_CTL_A;
        bus(1'b1, OFS_LEVEL_CTL_B, 32'h1234_5678, rd);
        b0 = 32'h1234_5678;
        settle();
        chk_quad(0, 4'hF, exp_set(1, a0, b0), 10'h000);
        `CHK("model", b0[12:8], eff_level[0])
        `CHK("model_de", {b0[15:13], a0[9:8]}, eff_deemph[0])
        bus(1'b0, OFS_LEVEL_CTL_A, 32'h0000_0000, rd);
        `CHK("ctl_a_rb", a0, rd)
        bus(1'b0, OFS_LEVEL_CTL_B, 32'h0000_0000, rd);
        `CHK("ctl_b_rb", b0, rd)
    endtask

    task automatic t_lane_sel();
        logic [9:0] old;
        old = exp_set(1, a0, b0);
        bus(1'b1, OFS_LANE_SEL, 32'h0000_0002, rd);
        bus(1'b0, OFS_LANE_SEL, 32'h0000_0000, rd);
        `CHK("sel_rb", 32'h0000_0002, rd)
        bus(1'b1, OFS_LEVEL_CTL_B, 32'h9ABC_DEF0, rd);
        b0 = 32'h9ABC_DEF0;
        settle();
        chk_quad(0, 4'h4, exp_set(1, a0, b0), old);
        bus(1'b1, OFS_LANE_SEL, 32'h0000_0010, rd);
        settle();
        chk_quad(0, 4'hF, exp_set(1, a0, b0), 10'h000);
        set_mode(0, 0);
        @(posedge mclk_i);
        deemph_6db_i[0] <= 1'b1; // Gen 1 must ignore the 6 dB select
        bus(1'b1, OFS_LEVEL_CTL_B, 32'h0F0F_0F6B, rd);
        b0 = 32'h0F0F_0F6B;
        settle();
        chk_quad(0, 4'hF, exp_set(0, a0, b0), 10'h000);
        bus(1'b0, OFS_MODE_STAT, 32'h0000_0000, rd);
        `CHK("mode_g1", 3'h0, rd[2:0])
    endtask

    task automatic t_margin();
        @(posedge mclk_i);
        transmit_margin_field_i[0] <= 3'h5;
        settle();
        for (int i = 0; i < 8; i++) begin
            `CHK("m_dir", i < 4, margin_direct_o[i])
            `CHK("m_lvl", (i < 4) ? 3'h5 : 3'h0, margin_level_o[i])
        end
        `CHK("m_eff", 5'h05, eff_level[1])
        @(posedge mclk_i);
        transmit_margin_field_i[0] <= MARGIN_NORMAL;
        settle();
        `CHK("m_off", 1'b0, margin_direct_o[1])
    endtask

    task automatic t_unmapped();
        bus(1'b1, 8'h24, 32'hFFFF_FFFF, rd);
        bus(1'b0, 8'h24, 32'h0000_0000, rd);
        `CHK("unmap", 32'h0000_0000, rd)
        bus(1'b1, 8'h16, 32'h0000_0000, rd);
        bus(1'b0, 8'h14, 32'h0000_0000, rd);
        `CHK("misalign", RST_LEVEL_CTL_B, rd)
    endtask

    // -------------------------------------------------------------------
    // Clock, watchdog and main sequence
    // -------------------------------------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end

    initial begin
        repeat (20000) @(posedge mclk_i);
        err_total++;
        finish_test();
    end

    initial begin
        rst_n_i = 1'b0;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_address_i = 8'h00;
        avs_writedata_i = 32'h0000_0000;
        low_swing_i = 2'h0;
        gen2_i = 2'h0;
        deemph_6db_i = 2'h0;
        transmit_margin_field_i = '0;
        a0 = RST_LEVEL_CTL_A;
        b0 = RST_LEVEL_CTL_B;
        repeat (20) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        settle();
        t_reset();
        t_modes();
        t_write();
        t_lane_sel();
        t_margin();
        t_unmapped();
        finish_test();
    end
endmodule
`default_nettype wire
